// ### core/regulator_control_map.svh
// Register offsets, field positions, reset values and settle counts of the regulator block.
// Included by regulator_settle and regulator_control; holds definitions only.
`ifndef REGULATOR_CONTROL_MAP_SVH
`define REGULATOR_CONTROL_MAP_SVH
`define TRX_CTRL_TWO_OFFSET 12'h00C
`define REG_CTRL_OFFSET 12'h010
`define STATE_CTRL_OFFSET 12'h020
`define TRX_CTRL_TWO_RESET 8'h24
`define REG_CTRL_RESET 8'h00
`define STATE_CTRL_RESET 8'h00
`define ANA_EXT_BIT 7
`define ANA_GOOD_BIT 6
`define DIG_EXT_BIT 3
`define DIG_GOOD_BIT 2
`define KEEP_ANA_BIT 6
`define STATE_OFF_BIT 0
`define STATE_SLEEP_BIT 1
`define SETTLE_TIME_NS 2000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + 39) / 40)
`endif

// ### core/regulator_control_pkg.sv
// Types shared by the regulator control block.
// Assumes regulator_control_map.svh is on the include path.
package regulator_control_pkg;
  typedef struct packed {
    logic analog_regulator_en;
    logic digital_regulator_en;
  } regulator_enable_t;
  typedef struct packed {
    logic analog_supply_good;
    logic digital_supply_good;
  } supply_good_t;
  typedef enum logic [2:0] {
    SETTLE_OFF = 3'b001,
    SETTLE_WAIT = 3'b010,
    SETTLE_GOOD = 3'b100
  } settle_state_t;
endpackage

// ### core/regulator_settle.sv
// One regulator's settle tracker: counts a settle time after enable.
// Assumes enable comes from logic on the same clock.
`timescale 1ns/100ps
`include "regulator_control_map.svh"
module regulator_settle (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Enable and result.
  input wire logic enable,
  output logic settled
);
  import regulator_control_pkg::*;
  localparam int unsigned CNT_W = 12;
  localparam logic [CNT_W-1:0] SETTLE_MAX = CNT_W'(`SETTLE_CYCLES - 1);
  settle_state_t state_q;
  logic [CNT_W-1:0] count_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SETTLE_OFF;
    end else if (!enable) begin
      state_q <= SETTLE_OFF;
    end else begin
      case (state_q)
        SETTLE_OFF: state_q <= SETTLE_WAIT;
        SETTLE_WAIT: begin
          if (count_q == SETTLE_MAX) begin
            state_q <= SETTLE_GOOD;
          end
        end
        SETTLE_GOOD: state_q <= SETTLE_GOOD;
        default: state_q <= SETTLE_OFF;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
    end else if (state_q != SETTLE_WAIT) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + CNT_W'(1);
    end
  end
  // A disabled or unsettled regulator reads as not good.
  assign settled = (state_q == SETTLE_GOOD);
endmodule // regulator_settle

// ### core/apb_reg_slave.sv
// Zero-wait APB slave front end: decodes a transfer into strobes.
// Assumes an APB master on clk; pready is driven by the parent, high for one cycle after setup.
`timescale 1ns/100ps
module apb_reg_slave (
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  // Decoded strobes.
  output logic wr_stb,
  output logic rd_stb,
  output logic [11:0] addr
);
  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && penable && !pwrite;
  assign addr = {paddr[11:2], 2'b00};
endmodule // apb_reg_slave

// ### core/regulator_control.sv
// Regulator control and status registers with settle tracking.
// Assumes an APB master on clk, which also writes the transceiver state register at 0x20.
// Operation
// - Regulator control register lives at offset 0x10, read and write.
// - Analog external select set turns the internal analog regulator off.
// - Digital external select set turns the internal digital regulator off.
// - Analog good flag reads one once the analog supply has settled.
// - Digital good flag reads one once the digital supply has settled.
// - A zero good flag means disabled or not yet settled.
// - External select forces that domain's good flag to one.
// - Digital good resets zero, yet practical reads return one.
// - Keep bit in control register 0x0C holds analog regulator on when off.
// - Configuration registers keep their contents through sleep.
`timescale 1ns/100ps
`include "regulator_control_map.svh"
module regulator_control (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Regulator controls and status.
  output regulator_control_pkg::regulator_enable_t reg_enable,
  output regulator_control_pkg::supply_good_t supply_good
);
  import regulator_control_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic wr_stb;
  logic rd_stb;
  logic [11:0] addr;
  logic [7:0] trx_ctrl_two_q;
  logic [7:0] reg_ctrl_q;
  logic [7:0] state_ctrl_q;
  logic ana_en_d;
  logic dig_en_d;
  logic ana_settled;
  logic dig_settled;
  logic ana_good;
  logic dig_good;
  logic [7:0] rd_byte;
  logic hit;
  apb_reg_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Registers have no sleep-driven clear, so contents survive sleep.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trx_ctrl_two_q <= `TRX_CTRL_TWO_RESET;
    end else if (wr_stb && addr == `TRX_CTRL_TWO_OFFSET) begin
      trx_ctrl_two_q <= pwdata[7:0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_ctrl_q <= `REG_CTRL_RESET;
    end else if (wr_stb && addr == `REG_CTRL_OFFSET) begin
      reg_ctrl_q <= pwdata[7:0];
      reg_ctrl_q[`ANA_GOOD_BIT] <= 1'b0;
      reg_ctrl_q[`DIG_GOOD_BIT] <= 1'b0;
    end
  end
  // Software-visible transceiver state: bit 0 off state, bit 1 sleep.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ctrl_q <= `STATE_CTRL_RESET;
    end else if (wr_stb && addr == `STATE_CTRL_OFFSET) begin
      state_ctrl_q <= {6'h00, pwdata[1:0]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // The main regulators drop out in sleep; a low-power one keeps the registers.
  always_comb begin
    ana_en_d = !reg_ctrl_q[`ANA_EXT_BIT];
    if (state_ctrl_q[`STATE_OFF_BIT] && !trx_ctrl_two_q[`KEEP_ANA_BIT]) begin
      ana_en_d = 1'b0;
    end
    if (state_ctrl_q[`STATE_SLEEP_BIT]) begin
      ana_en_d = 1'b0;
    end
    dig_en_d = !reg_ctrl_q[`DIG_EXT_BIT] && !state_ctrl_q[`STATE_SLEEP_BIT];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_enable <= '0;
    end else begin
      reg_enable.analog_regulator_en <= ana_en_d;
      reg_enable.digital_regulator_en <= dig_en_d;
    end
  end
  regulator_settle u_ana (
    .clk(clk),
    .arst_n(arst_n),
    .enable(reg_enable.analog_regulator_en),
    .settled(ana_settled)
  );
  regulator_settle u_dig (
    .clk(clk),
    .arst_n(arst_n),
    .enable(reg_enable.digital_regulator_en),
    .settled(dig_settled)
  );
  assign ana_good = ana_settled || reg_ctrl_q[`ANA_EXT_BIT];
  assign dig_good = dig_settled || reg_ctrl_q[`DIG_EXT_BIT];
  // The digital flag starts at zero and rises once settled; reads in use see one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_good <= '0;
    end else begin
      supply_good.analog_supply_good <= ana_good;
      supply_good.digital_supply_good <= dig_good;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_byte = 8'h00;
    hit = 1'b1;
    case (addr)
      `TRX_CTRL_TWO_OFFSET: rd_byte = trx_ctrl_two_q;
      `REG_CTRL_OFFSET: begin
        rd_byte = reg_ctrl_q;
        rd_byte[`ANA_GOOD_BIT] = supply_good.analog_supply_good;
        rd_byte[`DIG_GOOD_BIT] = supply_good.digital_supply_good;
      end
      `STATE_CTRL_OFFSET: rd_byte = state_ctrl_q;
      default: hit = 1'b0;
    endcase
  end
  // Read data is registered at the setup-phase edge, so it appears in the access phase with pready.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end
endmodule // regulator_control

// ### dv/regulator_control_properties.sv
// Concurrent checks on the regulator control block ports.
// Assumes a bind onto regulator_control with one clock domain.
`timescale 1ns/100ps
module regulator_control_properties (
  // Clock, reset and APB.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Regulator outputs.
  input wire regulator_control_pkg::regulator_enable_t reg_enable,
  input wire regulator_control_pkg::supply_good_t supply_good
);
  import regulator_control_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic vwr;
  assign vwr = psel && penable && pwrite && paddr[11:2] == 10'h004;
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_error: assert property (psel && !penable &&
    !(paddr[11:2] inside {10'h003, 10'h004, 10'h008}) |=> pslverr)
    else $error("unmapped access without pslverr");
  a_analog_ext_off: assert property (vwr && pwdata[7] |->
    ##[1:2] !reg_enable.analog_regulator_en) else $error("analog regulator stays on");
  a_digital_ext_off: assert property (vwr && pwdata[3] |->
    ##[1:2] !reg_enable.digital_regulator_en) else $error("digital regulator stays on");
  a_analog_forced_good: assert property (vwr && pwdata[7] |->
    ##[1:2] supply_good.analog_supply_good) else $error("analog good not forced");
  a_digital_forced_good: assert property (vwr && pwdata[3] |->
    ##[1:2] supply_good.digital_supply_good) else $error("digital good not forced");
  a_good_waits_settle: assert property ($rose(reg_enable.analog_regulator_en) |->
    !supply_good.analog_supply_good [*8]) else $error("analog good before settling");
  a_good_after_settle: assert property ($rose(reg_enable.digital_regulator_en) |->
    ##[45:60] supply_good.digital_supply_good) else $error("digital good never set");
  cover property (pslverr);
  cover property (vwr && pwdata[7]);
  cover property ($rose(supply_good.digital_supply_good));
endmodule // regulator_control_properties

// ### dv/regulator_control_tb.sv
// Self-checking bench for the regulator control block.
// Assumes the design files and the properties file are compiled first.
`timescale 1ns/100ps
module regulator_control_tb;
  import regulator_control_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  regulator_enable_t reg_enable;
  supply_good_t supply_good;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] d;
  always #20 clk = ~clk;
  regulator_control dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reg_enable(reg_enable), .supply_good(supply_good));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_ctrl(input logic [7:0] v, input logic ag, input logic dg);
    return (v & 8'hBB) | {1'b0, ag, 3'b000, dg, 2'b00};
  endfunction
  // The master holds the request until the edge where pready is sampled high.
  task automatic rw(input logic w, input logic [11:0] a, input logic [7:0] v);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, v};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 8'h01, {7'h00, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h6144_be70));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (70) @(posedge clk);
    rw(1'b0, 12'h00C, 8'h00);
    chk("transceiver_control_two", 8'h24, rd[7:0]);
    rw(1'b0, 12'h010, 8'h00);
    chk("regulator_control", 8'h44, rd[7:0]);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'h33 : 8'($urandom());
      rw(1'b1, 12'h010, d);
      repeat (70) @(posedge clk);
      rw(1'b0, 12'h010, 8'h00);
      chk("regulator_control", exp_ctrl(d, 1'b1, 1'b1), rd[7:0]);
      chk("reg_enable", {6'h00, ~d[7], ~d[3]}, {6'h00, reg_enable});
    end
    rw(1'b1, 12'h010, 8'h88);
    repeat (5) @(posedge clk);
    rw(1'b0, 12'h010, 8'h00);
    chk("forced good", 8'hCC, rd[7:0]);
    rw(1'b1, 12'h010, 8'h30);
    rw(1'b0, 12'h010, 8'h00);
    chk("unsettled good", 8'h30, rd[7:0]);
    repeat (70) @(posedge clk);
    rw(1'b0, 12'h010, 8'h00);
    chk("settled good", 8'h74, rd[7:0]);
    rw(1'b1, 12'h020, 8'h02);
    rw(1'b1, 12'h020, 8'h00);
    repeat (70) @(posedge clk);
    rw(1'b0, 12'h010, 8'h00);
    chk("after sleep", 8'h74, rd[7:0]);
    rw(1'b1, 12'h020, 8'h01);
    repeat (2) @(posedge clk);
    chk("analog off", 8'h00, {7'h00, reg_enable.analog_regulator_en});
    rw(1'b1, 12'h00C, 8'h64);
    repeat (2) @(posedge clk);
    chk("analog kept", 8'h01, {7'h00, reg_enable.analog_regulator_en});
    rw(1'b0, 12'h040, 8'h00);
    chk("unmapped data", 8'h00, rd[7:0]);
    chk("unmapped err", 8'h01, {7'h00, er});
    complete_run();
  end
endmodule // regulator_control_tb
bind regulator_control regulator_control_properties chk_u (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .reg_enable(reg_enable),
  .supply_good(supply_good));
